// ===== acdm_core.sv
`timescale 1ns/1ns
`include "acdm_consts.svh"
module acdm_core #(
  parameter int unsigned ASLP_TICK_CYC = `ACDM_ASLP_TICK_MS * `ACDM_CLK_KHZ
) (
  input wire logic clk,
  input wire logic resetn,
  input wire acdm_pkg::acdm_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic [2:0] trim_addr,
  input wire logic [7:0] trim_data,
  input wire logic sample_valid,
  input wire acdm_pkg::acdm_raw_s sample_raw,
  input wire logic [2:0][11:0] sample_hp,
  input wire acdm_pkg::acdm_ext_evt_s ext_evt,
  output acdm_pkg::acdm_mode_s mode,
  output logic ffmt_event,
  output logic orient_landscape,
  output logic data_ready
);
  import acdm_pkg::*;

  localparam logic [`ACDM_TICK_W-1:0] TICK_LAST = `ACDM_TICK_W'(ASLP_TICK_CYC - 1);

  acdm_state_s s_r;
  acdm_state_s s_nxt;
  acdm_cnt_t [2:0] conv;

  function automatic logic [11:0] abs12(input logic [11:0] v);
    abs12 = v[11] ? 12'(-v) : v;
  endfunction

  function automatic logic [7:0] abs8(input logic [7:0] v);
    abs8 = v[7] ? 8'(-v) : v;
  endfunction

  // Next address of the auto-incrementing pointer
  function automatic logic [7:0] ptr_next(input logic [7:0] a, input logic fast);
    if (fast && (a == `ACDM_A_OUT_X_HI || a == `ACDM_A_OUT_X_HI + 8'h02)) begin
      ptr_next = a + 8'h02;
    end else if (fast && a == `ACDM_A_OUT_X_HI + 8'h04) begin
      ptr_next = `ACDM_A_OUT_Z_LO + 8'h01;
    end else begin
      ptr_next = a + 8'h01;
    end
  endfunction

  function automatic logic [7:0] rd_val(input acdm_state_s st, input logic [7:0] a);
    rd_val = 8'h00;
    case (a)
      `ACDM_A_STATUS: rd_val = {4'h0, st.drdy, 3'h0};
      `ACDM_A_SYSMODE: rd_val = {6'h00, st.sleeping & st.ctrl_a[`ACDM_CA_ACTIVE],
                                 ~st.sleeping & st.ctrl_a[`ACDM_CA_ACTIVE]};
      `ACDM_A_RANGE: rd_val = st.range;
      `ACDM_A_FFMT_CFG: rd_val = st.ffmt_cfg;
      `ACDM_A_FFMT_SRC: rd_val = {st.ffmt_flag, 7'h00};
      `ACDM_A_FFMT_THS: rd_val = st.ffmt_ths;
      `ACDM_A_FFMT_CNT: rd_val = st.ffmt_cnt;
      `ACDM_A_ASLP_CNT: rd_val = st.aslp_cnt;
      `ACDM_A_CTRL_A: rd_val = st.ctrl_a;
      `ACDM_A_CTRL_B: rd_val = st.ctrl_b;
      `ACDM_A_CTRL_C: rd_val = st.ctrl_c;
      default: begin
        if (a >= `ACDM_A_OUT_X_HI && a <= `ACDM_A_OUT_Z_LO) begin
          rd_val = st.out[3'(a - `ACDM_A_OUT_X_HI)];
        end else if (a >= `ACDM_A_OFF_X && a <= `ACDM_A_OFF_Z) begin
          rd_val = st.usr_off[2'(a - `ACDM_A_OFF_X)];
        end
      end
    endcase
  endfunction

  // Trim bytes 0..2 are gain, 3..5 are zero-g offset
  for (genvar i = 0; i < 3; i++) begin : g_axis
    acdm_axis u_axis (
      .raw(i == 0 ? sample_raw.x : (i == 1 ? sample_raw.y : sample_raw.z)),
      .sens_trim(s_r.trim[i]),
      .fac_off(s_r.trim[i + 3]),
      .usr_off(s_r.usr_off[i]),
      .range(s_r.range[1:0]),
      .low_noise(s_r.ctrl_a[`ACDM_CA_LOW_NOISE]),
      .cnt(conv[i])
    );
  end

  always_comb begin
    logic active;
    logic fast;
    logic motion;
    logic cond;
    logic any_en;
    logic all_below;
    logic any_above;
    logic [7:0] mag;
    logic [19:0] ax;
    logic [19:0] ay;
    logic wake;
    logic tick;
    logic [3:0] idx;
    active = 1'b0;
    fast = 1'b0;
    motion = 1'b0;
    cond = 1'b0;
    any_en = 1'b0;
    all_below = 1'b1;
    any_above = 1'b0;
    mag = 8'h00;
    ax = 20'h00000;
    ay = 20'h00000;
    wake = 1'b0;
    tick = 1'b0;
    idx = 4'h0;
    s_nxt = s_r;
    s_nxt.orient_evt = 1'b0;
    active = s_r.ctrl_a[`ACDM_CA_ACTIVE];
    fast = s_r.ctrl_a[`ACDM_CA_FREAD];
    motion = s_r.ffmt_cfg[`ACDM_FC_MOTION];
    s_nxt.act_d = active;

    case (s_r.st)
      ACDM_TRIM: begin
        s_nxt.trim[s_r.trim_idx] = trim_data;
        s_nxt.trim_idx = s_r.trim_idx + 3'h1;
        if (s_r.trim_idx == `ACDM_TRIM_LAST) begin
          s_nxt.st = ACDM_RUN;
        end
      end
      ACDM_RUN: begin
        // Register port: pointer load, read with advance, write with advance
        if (reg_req.start) begin
          s_nxt.ptr = reg_req.addr;
        end else if (reg_req.rd) begin
          s_nxt.rdata = rd_val(s_r, s_r.ptr);
          s_nxt.ptr = ptr_next(s_r.ptr, fast);
          if (s_r.ptr == `ACDM_A_OUT_X_HI) begin
            s_nxt.drdy = 1'b0;
          end
          if (s_r.ptr == `ACDM_A_FFMT_SRC) begin
            s_nxt.ffmt_flag = 1'b0;
          end
        end else if (reg_req.wr) begin
          s_nxt.ptr = ptr_next(s_r.ptr, fast);
          case (s_r.ptr)
            `ACDM_A_RANGE: s_nxt.range = {6'h00, reg_req.wdata[1:0]};
            `ACDM_A_FFMT_CFG: s_nxt.ffmt_cfg = reg_req.wdata;
            `ACDM_A_FFMT_THS: s_nxt.ffmt_ths = reg_req.wdata;
            `ACDM_A_FFMT_CNT: s_nxt.ffmt_cnt = reg_req.wdata;
            `ACDM_A_ASLP_CNT: s_nxt.aslp_cnt = reg_req.wdata;
            `ACDM_A_CTRL_A: s_nxt.ctrl_a = reg_req.wdata;
            `ACDM_A_CTRL_B: s_nxt.ctrl_b = reg_req.wdata;
            `ACDM_A_CTRL_C: s_nxt.ctrl_c = reg_req.wdata;
            default: begin
              if (s_r.ptr >= `ACDM_A_OFF_X && s_r.ptr <= `ACDM_A_OFF_Z) begin
                s_nxt.usr_off[2'(s_r.ptr - `ACDM_A_OFF_X)] = reg_req.wdata;
              end
            end
          endcase
        end

        // Commit held sample once no burst is in flight
        if (s_r.pend_v && !reg_req.burst) begin
          for (int i = 0; i < 3; i++) begin
            idx = 4'(2 * i);
            s_nxt.out[idx] = s_r.pend[i][11:4];
            s_nxt.out[idx + 4'h1] = {s_r.pend[i][3:0], 4'h0};
          end
          s_nxt.pend_v = 1'b0;
          s_nxt.drdy = 1'b1;

          // Shared freefall/motion channel on high-byte magnitudes
          for (int i = 0; i < 3; i++) begin
            if (s_r.ffmt_cfg[`ACDM_FC_X_EN + i]) begin
              any_en = 1'b1;
              if (motion && s_r.ffmt_cfg[`ACDM_FC_HPF]) begin
                mag = abs8(s_r.pend_hp[i][11:4]);
              end else begin
                mag = abs8(s_r.pend[i][11:4]);
              end
              if (mag > s_r.ffmt_ths) begin
                any_above = 1'b1;
              end
              if (mag >= s_r.ffmt_ths) begin
                all_below = 1'b0;
              end
            end
          end
          cond = any_en && (motion ? any_above : all_below);
          if (cond) begin
            if (s_r.db_cnt >= s_r.ffmt_cnt) begin
              s_nxt.ffmt_flag = 1'b1;
            end else begin
              s_nxt.db_cnt = s_r.db_cnt + 8'h01;
            end
          end else begin
            s_nxt.db_cnt = 8'h00;
          end

          // Fixed-hysteresis orientation on X/Y
          ax = 20'(abs12(s_r.pend[0])) * 20'(`ACDM_TAN30_Q8);
          ay = {abs12(s_r.pend[1]), 8'h00};
          if (!s_r.landscape && ay < ax) begin
            s_nxt.landscape = 1'b1;
            s_nxt.orient_evt = 1'b1;
          end
          ax = 20'(abs12(s_r.pend[0])) * 20'(`ACDM_TAN60_Q8);
          if (s_r.landscape && ay > ax) begin
            s_nxt.landscape = 1'b0;
            s_nxt.orient_evt = 1'b1;
          end
        end

        // A new sample replaces any uncommitted one
        if (sample_valid && active) begin
          for (int i = 0; i < 3; i++) begin
            s_nxt.pend[i] = conv[i];
            s_nxt.pend_hp[i] = sample_hp[i];
          end
          s_nxt.pend_v = 1'b1;
        end

        // Auto sleep: time-out ticks while no enabled event arrives
        wake = (s_r.ctrl_c[`ACDM_CC_WAKE_FFMT] && s_nxt.ffmt_flag && !s_r.ffmt_flag)
             || (s_r.ctrl_c[`ACDM_CC_WAKE_PULSE] && ext_evt.pulse)
             || (s_r.ctrl_c[`ACDM_CC_WAKE_ORIENT] && s_nxt.orient_evt)
             || (s_r.ctrl_c[`ACDM_CC_WAKE_TRANS] && ext_evt.transient);
        tick = (s_r.tick_cnt == TICK_LAST);
        s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + `ACDM_TICK_W'(1);
        if (!active || !s_r.ctrl_b[`ACDM_CB_ASLP_EN] || wake) begin
          s_nxt.sleep_cnt = 8'h00;
          s_nxt.sleeping = 1'b0;
          s_nxt.tick_cnt = '0;
        end else if (tick) begin
          if (s_r.sleep_cnt >= s_r.aslp_cnt) begin
            s_nxt.sleeping = 1'b1;
          end else begin
            s_nxt.sleep_cnt = s_r.sleep_cnt + 8'h01;
          end
        end

        // Entering active clears flags, debounce and sleep state; orientation, output bytes and settings kept
        if (active && !s_r.act_d) begin
          s_nxt.drdy = 1'b0;
          s_nxt.ffmt_flag = 1'b0;
          s_nxt.db_cnt = 8'h00;
          s_nxt.pend_v = sample_valid;
          s_nxt.sleep_cnt = 8'h00;
          s_nxt.sleeping = 1'b0;
          s_nxt.tick_cnt = '0;
        end
      end
      default: begin
        s_nxt.st = ACDM_TRIM;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.st <= ACDM_TRIM;
      s_r.aslp_cnt <= `ACDM_RST_ASLP;
      s_r.ctrl_a <= `ACDM_RST_BYTE;
      s_r.ctrl_b <= `ACDM_RST_BYTE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign trim_addr = s_r.trim_idx;
  assign ffmt_event = s_r.ffmt_flag;
  assign orient_landscape = s_r.landscape;
  assign data_ready = s_r.drdy;

  always_comb begin
    mode.active = s_r.ctrl_a[`ACDM_CA_ACTIVE];
    mode.sleeping = s_r.sleeping && s_r.ctrl_a[`ACDM_CA_ACTIVE];
    mode.low_noise = s_r.ctrl_a[`ACDM_CA_LOW_NOISE];
    if (mode.sleeping) begin
      mode.rate = {1'b1, s_r.ctrl_a[`ACDM_CA_SRATE_HI:`ACDM_CA_SRATE_LO]};
      mode.scheme = s_r.ctrl_b[`ACDM_CB_SOS_HI:`ACDM_CB_SOS_LO];
    end else begin
      mode.rate = s_r.ctrl_a[`ACDM_CA_RATE_HI:`ACDM_CA_RATE_LO];
      mode.scheme = s_r.ctrl_b[`ACDM_CB_OS_HI:`ACDM_CB_OS_LO];
    end
    mode.hires_out = (mode.scheme == `ACDM_OS_HIRES);
    mode.low_power = (mode.scheme == `ACDM_OS_LOWPWR)
                   || (mode.rate == `ACDM_RATE_SLOWEST);
  end
endmodule // acdm_core

// ===== acdm_consts.svh
`ifndef ACDM_CONSTS_SVH
`define ACDM_CONSTS_SVH

// Register map offsets
`define ACDM_A_STATUS 8'h00
`define ACDM_A_OUT_X_HI 8'h01
`define ACDM_A_OUT_Z_LO 8'h06
`define ACDM_A_SYSMODE 8'h0B
`define ACDM_A_RANGE 8'h0E
`define ACDM_A_FFMT_CFG 8'h15
`define ACDM_A_FFMT_SRC 8'h16
`define ACDM_A_FFMT_THS 8'h17
`define ACDM_A_FFMT_CNT 8'h18
`define ACDM_A_ASLP_CNT 8'h29
`define ACDM_A_CTRL_A 8'h2A
`define ACDM_A_CTRL_B 8'h2B
`define ACDM_A_CTRL_C 8'h2C
`define ACDM_A_OFF_X 8'h2F
`define ACDM_A_OFF_Z 8'h31

// system_control_a fields
`define ACDM_CA_ACTIVE 0
`define ACDM_CA_FREAD 1
`define ACDM_CA_LOW_NOISE 2
`define ACDM_CA_RATE_LO 3
`define ACDM_CA_RATE_HI 5
`define ACDM_CA_SRATE_LO 6
`define ACDM_CA_SRATE_HI 7
// system_control_b fields
`define ACDM_CB_OS_LO 0
`define ACDM_CB_OS_HI 1
`define ACDM_CB_ASLP_EN 2
`define ACDM_CB_SOS_LO 3
`define ACDM_CB_SOS_HI 4
// system_control_c wake enables
`define ACDM_CC_WAKE_FFMT 3
`define ACDM_CC_WAKE_PULSE 4
`define ACDM_CC_WAKE_ORIENT 5
`define ACDM_CC_WAKE_TRANS 6
// Freefall/motion configuration fields
`define ACDM_FC_HPF 0
`define ACDM_FC_X_EN 3
`define ACDM_FC_Z_EN 5
`define ACDM_FC_MOTION 6

// Reset values
`define ACDM_RST_BYTE 8'h00
`define ACDM_RST_ASLP 8'h08

// Encodings and scaling
`define ACDM_OS_HIRES 2'h2
`define ACDM_OS_LOWPWR 2'h3
`define ACDM_RATE_SLOWEST 3'h7
`define ACDM_RANGE_8G 2'h2
`define ACDM_SENS_UNITY 11'sh100
`define ACDM_FS_POS 12'sh7FF
`define ACDM_FS_NEG 12'sh800
`define ACDM_LN_POS 12'sh400
`define ACDM_LN_NEG 12'shC00
`define ACDM_TAN30_Q8 9'h094
`define ACDM_TAN60_Q8 9'h1BB
`define ACDM_TRIM_LAST 3'h5

// Timing
`define ACDM_CLK_KHZ 20000
`define ACDM_ASLP_TICK_MS 320
`define ACDM_TICK_W 24

`endif

// ===== acdm_pkg.sv
`include "acdm_consts.svh"

package acdm_pkg;

  typedef logic signed [15:0] acdm_raw_t;
  typedef logic signed [11:0] acdm_cnt_t;

  typedef struct packed {
    acdm_raw_t x;
    acdm_raw_t y;
    acdm_raw_t z;
  } acdm_raw_s;

  typedef struct packed {
    logic start;
    logic burst;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acdm_reg_req_s;

  typedef struct packed {
    logic [2:0] rate;
    logic [1:0] scheme;
    logic low_noise;
    logic hires_out;
    logic low_power;
    logic active;
    logic sleeping;
  } acdm_mode_s;

  typedef struct packed {
    logic pulse;
    logic transient;
  } acdm_ext_evt_s;

  typedef enum logic [1:0] {
    ACDM_TRIM = 2'b00,
    ACDM_RUN = 2'b01
  } acdm_st_e;

  typedef struct packed {
    acdm_st_e st;
    logic [2:0] trim_idx;
    logic [5:0][7:0] trim;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [7:0] range;
    logic [7:0] ffmt_cfg;
    logic [7:0] ffmt_ths;
    logic [7:0] ffmt_cnt;
    logic [7:0] aslp_cnt;
    logic [2:0][7:0] usr_off;
    logic [5:0][7:0] out;
    logic [2:0][11:0] pend;
    logic [2:0][11:0] pend_hp;
    logic pend_v;
    logic drdy;
    logic ffmt_flag;
    logic [7:0] db_cnt;
    logic landscape;
    logic orient_evt;
    logic sleeping;
    logic [7:0] sleep_cnt;
    logic [`ACDM_TICK_W-1:0] tick_cnt;
    logic [7:0] ptr;
    logic [7:0] rdata;
    logic act_d;
  } acdm_state_s;

endpackage

// ===== acdm_axis.sv
`timescale 1ns/1ns
`include "acdm_consts.svh"
module acdm_axis (
  input wire acdm_pkg::acdm_raw_t raw,
  input wire logic [7:0] sens_trim,
  input wire logic [7:0] fac_off,
  input wire logic [7:0] usr_off,
  input wire logic [1:0] range,
  input wire logic low_noise,
  output acdm_pkg::acdm_cnt_t cnt
);
  import acdm_pkg::*;

  logic signed [10:0] gain;
  logic signed [26:0] prod;
  logic signed [18:0] corr;
  logic signed [18:0] scaled;
  logic signed [18:0] hi_lim;
  logic signed [18:0] lo_lim;

  // Factory gain trim is a signed Q8 correction around unity
  assign gain = `ACDM_SENS_UNITY + 11'(signed'(sens_trim));
  assign prod = 27'(raw) * 27'(gain);
  // Raw data is in 1/1024 g; user offset steps are two of those
  assign corr = 19'(prod >>> 8) + 19'(signed'(fac_off)) + (19'(signed'(usr_off)) <<< 1);
  // Shift sets 1024, 512, 256 or 128 counts per g
  assign scaled = corr >>> range;
  // Low noise caps the usable span at 4g, in the 8g range only
  assign hi_lim = (low_noise && range == `ACDM_RANGE_8G) ? 19'(`ACDM_LN_POS)
                                                       : 19'(`ACDM_FS_POS);
  assign lo_lim = (low_noise && range == `ACDM_RANGE_8G) ? 19'(`ACDM_LN_NEG)
                                                       : 19'(`ACDM_FS_NEG);

  always_comb begin
    if (scaled > hi_lim) begin
      cnt = 12'(hi_lim);
    end else if (scaled < lo_lim) begin
      cnt = 12'(lo_lim);
    end else begin
      cnt = 12'(scaled);
    end
  end
endmodule // acdm_axis

// ===== acdm_core_monitor.sv
`timescale 1ns/1ns
module acdm_core_monitor
  import acdm_pkg::*;
#(
  parameter int unsigned ASLP_TICK_CYC = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire acdm_pkg::acdm_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] trim_addr,
  input wire logic sample_valid,
  input wire acdm_pkg::acdm_ext_evt_s ext_evt,
  input wire acdm_pkg::acdm_mode_s mode,
  input wire logic ffmt_event,
  input wire logic data_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Sample accepted and never held back by a host transfer
  sequence s_take;
    sample_valid && mode.active && !reg_req.burst ##1 !reg_req.burst
      ##1 !reg_req.burst && !reg_req.rd && !reg_req.wr;
  endsequence
  sequence s_no_wake;
    !ext_evt.pulse && !ext_evt.transient && !$past(ext_evt.pulse) && !$past(ext_evt.transient);
  endsequence

  property p_trim_step;
    trim_addr inside {[3'h1:3'h4]} |=> trim_addr == $past(trim_addr) + 3'h1;
  endproperty
  property p_reset_clean;
    $rose(resetn) |-> mode == '0 && !data_ready && !ffmt_event && trim_addr == 3'h0;
  endproperty
  property p_hires;
    mode.hires_out == (mode.scheme == 2'h2);
  endproperty
  property p_lowpwr;
    mode.low_power == (mode.scheme == 2'h3 || mode.rate == 3'h7);
  endproperty
  property p_commit;
    s_take |=> data_ready;
  endproperty
  property p_burst_hold;
    $rose(data_ready) |-> !$past(reg_req.burst);
  endproperty
  property p_sleep_rate;
    mode.sleeping |-> mode.rate[2] && mode.active;
  endproperty
  property p_stay_asleep;
    mode.sleeping && !reg_req.wr && !$past(reg_req.wr) && !sample_valid && !$past(sample_valid)
      && !$past(sample_valid, 2) && !$past(reg_req.burst) ##0 s_no_wake |=> mode.sleeping;
  endproperty
  property p_rdata_stands;
    !reg_req.rd && !$past(reg_req.rd) |=> $stable(reg_rdata);
  endproperty

  a_trim_step: assert property (p_trim_step) else $error("trim index skipped");
  a_reset_clean: assert property (p_reset_clean) else $error("outputs not clear");
  a_hires: assert property (p_hires) else $error("hires decode wrong");
  a_lowpwr: assert property (p_lowpwr) else $error("low power decode wrong");
  a_commit: assert property (p_commit) else $error("sample not committed");
  a_burst_hold: assert property (p_burst_hold) else $error("commit during burst");
  a_sleep_rate: assert property (p_sleep_rate) else $error("sleep rate wrong");
  a_stay_asleep: assert property (p_stay_asleep) else $error("woke without event");
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
endmodule // acdm_core_monitor

bind acdm_core acdm_core_monitor #(.ASLP_TICK_CYC(ASLP_TICK_CYC)) u_mon (
  .clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .trim_addr(trim_addr), .sample_valid(sample_valid), .ext_evt(ext_evt), .mode(mode),
  .ffmt_event(ffmt_event), .data_ready(data_ready));

// ===== acdm_trim_store.sv
`timescale 1ns/1ns
module acdm_trim_store #(
  parameter logic [47:0] TRIM_IMAGE = 48'h0
) (
  input wire logic [2:0] trim_addr,
  output logic [7:0] trim_data
);
  // Gains at 0..2, offsets at 3..5; unused addresses show a pattern, not a stale byte
  always_comb begin
    trim_data = 8'hA5;
    if (trim_addr <= 3'h5) begin
      trim_data = TRIM_IMAGE[trim_addr*8 +: 8];
    end
  end
endmodule // acdm_trim_store

// ===== acdm_core_tb.sv
`timescale 1ns/1ns
module acdm_core_tb;
  import acdm_pkg::*;
  logic clk;
  logic resetn;
  acdm_reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic [2:0] trim_addr;
  logic [7:0] trim_data;
  logic sample_valid;
  acdm_raw_s sample_raw;
  logic [2:0][11:0] sample_hp;
  acdm_ext_evt_s ext_evt;
  acdm_mode_s mode;
  logic ffmt_event;
  logic orient_landscape;
  logic data_ready;
  int n_fail;
  int check_count;
  logic [7:0] d;
  logic [15:0] ox [5];
  logic [15:0] oy [5];
  logic [4:0] ol;

  acdm_core #(.ASLP_TICK_CYC(4)) u_dut (
    .clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .trim_addr(trim_addr), .trim_data(trim_data), .sample_valid(sample_valid),
    .sample_raw(sample_raw), .sample_hp(sample_hp), .ext_evt(ext_evt), .mode(mode),
    .ffmt_event(ffmt_event), .orient_landscape(orient_landscape), .data_ready(data_ready));
  acdm_trim_store u_trim (.trim_addr(trim_addr), .trim_data(trim_data));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic set_ptr(input logic [7:0] a);
    @(posedge clk);
    reg_req.start <= 1'b1;
    reg_req.addr <= a;
    @(posedge clk);
    reg_req.start <= 1'b0;
  endtask

  task automatic rd_next;
    @(posedge clk);
    reg_req.rd <= 1'b1;
    @(posedge clk);
    reg_req.rd <= 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    set_ptr(a);
    reg_req.wr <= 1'b1;
    reg_req.wdata <= v;
    @(posedge clk);
    reg_req.wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    set_ptr(a);
    rd_next();
    check(d, exp);
  endtask

  task automatic send(input acdm_raw_t x, input acdm_raw_t y, input acdm_raw_t z,
                      input logic [11:0] hx);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_raw <= {x, y, z};
    sample_hp <= {24'h000000, hx};
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Full six-byte readout from the first output byte, X first
  task automatic chk_axes(input logic [35:0] c);
    logic [11:0] v;
    set_ptr(8'h01);
    for (int i = 0; i < 6; i++) begin
      v = c[35-12*(i/2) -: 12];
      rd_next();
      check(d, i[0] ? {v[3:0], 4'h0} : v[7+4 -: 8]);
    end
  endtask

  task automatic evt(input logic p, input logic t);
    @(posedge clk);
    ext_evt <= {p, t};
    @(posedge clk);
    ext_evt <= 2'h0;
    @(posedge clk);
    #1;
  endtask

  initial begin
    resetn = 1'b0;
    reg_req = '0;
    sample_valid = 1'b0;
    sample_raw = '0;
    sample_hp = '0;
    ext_evt = '0;
    n_fail = 0;
    check_count = 0;
    ox = '{16'h0000, 16'h0400, 16'h0400, 16'h0400, 16'h0000};
    oy = '{16'h0400, 16'h0300, 16'h0000, 16'h0300, 16'h0400};
    ol = 5'b01100;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    #1 check({data_ready, ffmt_event}, 16'h0000);
    check(trim_addr, 16'h0006);
    chk_reg(8'h29, 8'h08);
    chk_reg(8'h2A, 8'h00);
    wr_reg(8'h40, 8'h5A);
    chk_reg(8'h40, 8'h00);
    for (int i = 0; i < 3; i++) wr_reg(8'h2F + i[7:0], 8'h11 * (i[7:0] + 8'h01));
    for (int i = 0; i < 3; i++) chk_reg(8'h2F + i[7:0], 8'h11 * (i[7:0] + 8'h01));
    for (int i = 0; i < 3; i++) wr_reg(8'h2F + i[7:0], 8'h00);
    wr_reg(8'h2A, 8'h01);
    for (int r = 0; r < 3; r++) begin
      wr_reg(8'h0E, r[7:0]);
      send(16'h0123 << r, 16'h0000 - (16'h0100 << r), 16'h0040 << r, 12'h000);
      check(data_ready, 16'h0001);
      chk_reg(8'h00, 8'h08);
      chk_axes({12'h123, 12'hF00, 12'h040});
      check(data_ready, 16'h0000);
    end
    wr_reg(8'h2A, 8'h05);
    check(mode.low_noise, 16'h0001);
    send(16'h1800, 16'h0000, 16'h0000, 12'h000);
    chk_axes({12'h400, 12'h000, 12'h000});
    wr_reg(8'h2A, 8'h03);
    send(16'h1800, 16'h0400, 16'hF800, 12'h000);
    set_ptr(8'h01);
    for (int i = 0; i < 3; i++) begin
      rd_next();
      check(d, i == 0 ? 8'h60 : (i == 1 ? 8'h10 : 8'hE0));
    end
    wr_reg(8'h2A, 8'h01);
    chk_axes({12'h600, 12'h100, 12'hE00});
    send(16'hD800, 16'h2800, 16'h0000, 12'h000);
    chk_axes({12'h800, 12'h7FF, 12'h000});
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'h2B, s[7:0]);
      check({mode.scheme, mode.hires_out, mode.low_power}, {s[1:0], s == 2, s == 3});
    end
    wr_reg(8'h2A, 8'h3D);
    check({mode.scheme, mode.low_noise, mode.low_power}, 16'h000F);
    wr_reg(8'h2A, 8'h01);
    wr_reg(8'h2B, 8'h00);
    wr_reg(8'h0E, 8'h00);
    @(posedge clk);
    reg_req.burst <= 1'b1;
    send(16'h0010, 16'h0000, 16'h0000, 12'h000);
    send(16'h0020, 16'h0000, 16'h0000, 12'h000);
    check(data_ready, 16'h0000);
    @(posedge clk);
    reg_req.burst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(data_ready, 16'h0001);
    chk_axes({12'h020, 12'h000, 12'h000});
    wr_reg(8'h17, 8'h10);
    wr_reg(8'h18, 8'h01);
    wr_reg(8'h15, 8'h49);
    send(16'h0400, 16'h0000, 16'h0000, 12'h000);
    set_ptr(8'h16);
    rd_next();
    send(16'h0400, 16'h0000, 16'h0000, 12'h000);
    send(16'h0400, 16'h0000, 16'h0000, 12'h000);
    check(ffmt_event, 16'h0000);
    wr_reg(8'h15, 8'h48);
    send(16'h0400, 16'h0000, 16'h0000, 12'h000);
    check(ffmt_event, 16'h0000);
    send(16'h0400, 16'h0000, 16'h0000, 12'h000);
    check(ffmt_event, 16'h0001);
    set_ptr(8'h16);
    rd_next();
    check({d[7], ffmt_event}, 16'h0002);
    wr_reg(8'h15, 8'h09);
    send(16'h0400, 16'h0000, 16'h0000, 12'h7FF);
    send(16'h0000, 16'h0000, 16'h0000, 12'h7FF);
    check(ffmt_event, 16'h0000);
    send(16'h0000, 16'h0000, 16'h0000, 12'h7FF);
    check(ffmt_event, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      send(ox[i], oy[i], 16'h0000, 12'h000);
      check(orient_landscape, ol[i]);
    end
    wr_reg(8'h29, 8'h02);
    wr_reg(8'h2C, 8'h10);
    wr_reg(8'h2A, 8'hC1);
    wr_reg(8'h2B, 8'h0D);
    repeat (40) @(posedge clk);
    #1 check({mode.sleeping, mode.rate, mode.scheme, mode.low_power}, 16'h007B);
    chk_reg(8'h0B, 8'h02);
    send(16'h0000, 16'h0000, 16'h0000, 12'h000);
    check(mode.sleeping, 16'h0001);
    evt(1'b0, 1'b1);
    check(mode.sleeping, 16'h0001);
    evt(1'b1, 1'b0);
    check({mode.sleeping, mode.rate, mode.scheme}, 16'h0001);
    chk_reg(8'h0B, 8'h01);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule // acdm_core_tb
